// ---- rtl/sme_escape_ctrl.sv ----
`timescale 1ns/10ps
// Overview of operation
// - Start in the configured operating mode, transparent by default.
// - Transparent mode forwards serial bytes to network and network bytes to serial.
// - No transparent pass-through while the host uses SPI.
// - API mode moves frame bytes over UART or SPI.
// - Command mode entry works only on UART, never on SPI.
// - Escape accepted only with guard silence before and after it.
// - Escape character and guard time are configurable settings.
// - On entry send O, K, carriage return, then take commands.
// - In command mode stop forwarding and treat input as commands.
// - Any UART byte during trailing guard cancels the pending entry.
// - Configured silence timeout, default ten seconds, leaves command mode.
// - Exit command leaves command mode at once.
// - Baud code defaults to 3, meaning 9600 b/s.
// - Six seconds of continuous break enters command mode.
// - Break held when reset ends starts the device in command mode.
// - Break entry forces 9600 baud and acknowledges at that rate.
// - Leaving command mode restores the configured baud code.
module sme_escape_ctrl #(
  parameter int TICK_CYCLES = sme_pkg::TICK_CYCLES_DEF
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_cfg_wr,
  input sme_pkg::sme_cfg_s i_cfg,
  input wire logic i_spi_sel,
  input sme_pkg::sme_byte_s i_uart_rx,
  input wire logic i_rx_break,
  input sme_pkg::sme_byte_s i_spi_rx,
  input sme_pkg::sme_byte_s i_net_rx,
  input wire logic i_uart_tx_ready,
  output sme_pkg::sme_byte_s o_uart_tx,
  output sme_pkg::sme_byte_s o_spi_tx,
  output sme_pkg::sme_byte_s o_net_tx,
  output logic o_net_framed,
  output sme_pkg::sme_byte_s o_cmd_rx,
  output logic o_cmd_mode,
  output logic [3:0] o_baud_code,
  output sme_pkg::sme_cfg_s o_cfg
);
  import sme_pkg::*;
  localparam int TW = $clog2(TICK_CYCLES + 1);
  typedef enum logic [1:0] {ST_DATA, ST_TRAIL, ST_ACK, ST_CMD} sme_state_e;
  function automatic logic [MS_W-1:0] sat_inc(input logic [MS_W-1:0] v, input logic en);
    sat_inc = (en && (v != {MS_W{1'b1}})) ? v + MS_W'(1) : v;
  endfunction
  function automatic logic [7:0] ack_char(input logic [1:0] i);
    case (i)
      2'h0: ack_char = CHAR_O;
      2'h1: ack_char = CHAR_K;
      default: ack_char = CHAR_CR;
    endcase
  endfunction
  sme_state_e st_r, st_nxt;
  sme_cfg_s cfg_r, cfg_nxt;
  logic [TW-1:0] tick_cnt_r, tick_cnt_nxt;
  logic [MS_W-1:0] idle_ms_r, idle_ms_nxt, brk_ms_r, brk_ms_nxt;
  logic [MS_W-1:0] win_ms_r, win_ms_nxt, cmd_ms_r, cmd_ms_nxt;
  logic [1:0] esc_cnt_r, esc_cnt_nxt, ack_idx_r, ack_idx_nxt;
  logic forced_r, forced_nxt, started_r, started_nxt;
  sme_byte_s tx_r, tx_nxt, spi_tx_r, spi_tx_nxt, net_tx_r, net_tx_nxt, cmd_rx_r, cmd_rx_nxt;
  logic framed_r, framed_nxt, cmd_mode_r, cmd_mode_nxt;
  logic [3:0] baud_r, baud_nxt;
  logic tick, uart_byte, is_esc, tx_free, exit_pulse, in_data, transparent;
  assign tick = (tick_cnt_r == TW'(TICK_CYCLES - 1));
  // SPI bytes never feed the escape logic
  assign uart_byte = i_uart_rx.valid && !i_spi_sel;
  assign is_esc = (i_uart_rx.data == cfg_r.esc_char);
  assign tx_free = !tx_r.valid || i_uart_tx_ready;
  assign in_data = (st_r == ST_DATA) || (st_r == ST_TRAIL);
  assign transparent = (cfg_r.opmode == MODE_TRANSPARENT);

  ////////////////////////////////////////////////////////////////////////////
  // Settings and millisecond timers
  always_comb begin
    cfg_nxt = i_cfg_wr ? i_cfg : cfg_r;
    tick_cnt_nxt = tick ? '0 : tick_cnt_r + TW'(1);
    // Silence since the last UART byte, either guard uses it
    idle_ms_nxt = uart_byte ? '0 : sat_inc(idle_ms_r, tick);
    brk_ms_nxt = i_rx_break ? sat_inc(brk_ms_r, tick) : '0;
    win_ms_nxt = (esc_cnt_r == 2'h0) ? '0 : sat_inc(win_ms_r, tick);
    cmd_ms_nxt = (st_r != ST_CMD || uart_byte) ? '0 : sat_inc(cmd_ms_r, tick);
  end
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cfg_r <= CFG_RESET;
      tick_cnt_r <= '0;
      idle_ms_r <= '0;
      brk_ms_r <= '0;
      win_ms_r <= '0;
      cmd_ms_r <= '0;
    end else begin
      cfg_r <= cfg_nxt;
      tick_cnt_r <= tick_cnt_nxt;
      idle_ms_r <= idle_ms_nxt;
      brk_ms_r <= brk_ms_nxt;
      win_ms_r <= win_ms_nxt;
      cmd_ms_r <= cmd_ms_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode control
  always_comb begin
    st_nxt = st_r;
    esc_cnt_nxt = esc_cnt_r;
    ack_idx_nxt = ack_idx_r;
    forced_nxt = forced_r;
    started_nxt = 1'b1;
    case (st_r)
      ST_DATA: begin
        if (!started_r && i_rx_break) begin
          st_nxt = ST_ACK;
          forced_nxt = 1'b1;
          esc_cnt_nxt = 2'h0;
        end else if (brk_ms_r >= BREAK_MS) begin
          st_nxt = ST_ACK;
          forced_nxt = 1'b1;
          esc_cnt_nxt = 2'h0;
        end else if (i_spi_sel) begin
          esc_cnt_nxt = 2'h0;
        end else if (uart_byte) begin
          if (!is_esc) begin
            esc_cnt_nxt = 2'h0;
          end else if (esc_cnt_r == 2'h0) begin
            esc_cnt_nxt = (idle_ms_r >= cfg_r.guard_ms) ? 2'h1 : 2'h0;
          end else if (win_ms_r >= ESC_WINDOW_MS) begin
            esc_cnt_nxt = 2'h0;
          end else if (esc_cnt_r + 2'h1 == ESC_COUNT) begin
            esc_cnt_nxt = 2'h0;
            st_nxt = ST_TRAIL;
          end else begin
            esc_cnt_nxt = esc_cnt_r + 2'h1;
          end
        end
      end
      ST_TRAIL: begin
        if (uart_byte) begin
          st_nxt = ST_DATA;
        end else if (idle_ms_r >= cfg_r.guard_ms) begin
          st_nxt = ST_ACK;
        end
      end
      ST_ACK: begin
        if (tx_free) begin
          ack_idx_nxt = ack_idx_r + 2'h1;
          if (ack_idx_r == ACK_LAST) begin
            ack_idx_nxt = 2'h0;
            st_nxt = ST_CMD;
          end
        end
      end
      ST_CMD: begin
        if (cmd_ms_r >= cfg_r.timeout_ms || exit_pulse) begin
          st_nxt = ST_DATA;
          forced_nxt = 1'b0;
        end
      end
      default: begin
        st_nxt = ST_DATA;
      end
    endcase
  end
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= ST_DATA;
      esc_cnt_r <= 2'h0;
      ack_idx_r <= 2'h0;
      forced_r <= 1'b0;
      started_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      esc_cnt_r <= esc_cnt_nxt;
      ack_idx_r <= ack_idx_nxt;
      forced_r <= forced_nxt;
      started_r <= started_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data paths; no buffering, a byte that meets a busy UART is dropped
  always_comb begin
    tx_nxt = tx_r;
    spi_tx_nxt = BYTE_IDLE;
    net_tx_nxt = BYTE_IDLE;
    cmd_rx_nxt = BYTE_IDLE;
    framed_nxt = !transparent;
    if (tx_r.valid && i_uart_tx_ready) begin
      tx_nxt.valid = 1'b0;
    end
    if (st_r == ST_ACK && tx_free) begin
      tx_nxt = '{valid: 1'b1, data: ack_char(ack_idx_r)};
    end else if (in_data && !transparent) begin
      // Frame bytes on the selected port
      net_tx_nxt = i_spi_sel ? i_spi_rx : i_uart_rx;
      if (i_spi_sel) begin
        spi_tx_nxt = i_net_rx;
      end else if (i_net_rx.valid && tx_free) begin
        tx_nxt = i_net_rx;
      end
    end else if (in_data && !i_spi_sel) begin
      // Transparent both ways, UART host only
      net_tx_nxt = i_uart_rx;
      if (i_net_rx.valid && tx_free) begin
        tx_nxt = i_net_rx;
      end
    end
    if (st_r == ST_CMD) begin
      cmd_rx_nxt = uart_byte ? i_uart_rx : BYTE_IDLE;
    end
    cmd_mode_nxt = (st_nxt == ST_ACK) || (st_nxt == ST_CMD);
    baud_nxt = forced_nxt ? BAUD_FORCED : cfg_nxt.baud;
  end
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tx_r <= BYTE_IDLE;
      spi_tx_r <= BYTE_IDLE;
      net_tx_r <= BYTE_IDLE;
      cmd_rx_r <= BYTE_IDLE;
      framed_r <= 1'b0;
      cmd_mode_r <= 1'b0;
      baud_r <= BAUD_DEF;
    end else begin
      tx_r <= tx_nxt;
      spi_tx_r <= spi_tx_nxt;
      net_tx_r <= net_tx_nxt;
      cmd_rx_r <= cmd_rx_nxt;
      framed_r <= framed_nxt;
      cmd_mode_r <= cmd_mode_nxt;
      baud_r <= baud_nxt;
    end
  end

  // Command line watch for the exit command
  sme_exit_scan u_scan (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_clear(st_r != ST_CMD),
    .i_byte(cmd_rx_nxt),
    .o_exit(exit_pulse)
  );

  assign o_uart_tx = tx_r;
  assign o_spi_tx = spi_tx_r;
  assign o_net_tx = net_tx_r;
  assign o_net_framed = framed_r;
  assign o_cmd_rx = cmd_rx_r;
  assign o_cmd_mode = cmd_mode_r;
  assign o_baud_code = baud_r;
  assign o_cfg = cfg_r;
  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  property p_start_mode;
    $rose(started_r) |-> (o_cmd_mode == $past(i_rx_break));
  endproperty
  a_start_mode: assert property (p_start_mode) else $error("wrong mode after reset");
  property p_transparent;
    (st_r == ST_DATA) && transparent && uart_byte |=> o_net_tx.valid && (o_net_tx.data == $past(i_uart_rx.data));
  endproperty
  a_transparent: assert property (p_transparent) else $error("serial byte not forwarded");
  property p_no_spi_pass;
    i_spi_sel && transparent |=> !o_net_tx.valid && !o_spi_tx.valid;
  endproperty
  a_no_spi_pass: assert property (p_no_spi_pass) else $error("pass-through over SPI");
  property p_spi_no_escape;
    i_spi_sel && (st_r == ST_DATA) |=> (esc_cnt_r == 2'h0) && (st_r != ST_TRAIL);
  endproperty
  a_spi_no_escape: assert property (p_spi_no_escape) else $error("escape counted over SPI");
  property p_trail_guard;
    (st_r == ST_TRAIL) && !uart_byte && (idle_ms_r >= cfg_r.guard_ms) |=> (st_r == ST_ACK);
  endproperty
  a_trail_guard: assert property (p_trail_guard) else $error("guard met but no entry");
  property p_trail_cancel;
    (st_r == ST_TRAIL) && uart_byte |=> (st_r == ST_DATA);
  endproperty
  a_trail_cancel: assert property (p_trail_cancel) else $error("entry not cancelled");
  property p_ack_end;
    (st_r == ST_ACK) && (st_nxt == ST_CMD) |=> o_uart_tx.valid && (o_uart_tx.data == CHAR_CR);
  endproperty
  a_ack_end: assert property (p_ack_end) else $error("acknowledge not ended by CR");
  property p_cmd_quiet;
    (st_r == ST_CMD) |=> !o_net_tx.valid;
  endproperty
  a_cmd_quiet: assert property (p_cmd_quiet) else $error("forwarding in command mode");
  property p_timeout;
    (st_r == ST_CMD) && (cmd_ms_r >= cfg_r.timeout_ms) |=> (st_r == ST_DATA) ##1 !o_cmd_mode;
  endproperty
  a_timeout: assert property (p_timeout) else $error("command timeout ignored");
  property p_exit;
    (st_r == ST_CMD) && exit_pulse |=> (st_r == ST_DATA);
  endproperty
  a_exit: assert property (p_exit) else $error("exit command ignored");
  property p_break;
    (st_r == ST_DATA) && started_r && (brk_ms_r >= BREAK_MS) |=> (st_r == ST_ACK) && forced_r;
  endproperty
  a_break: assert property (p_break) else $error("long break did not enter");
  property p_forced_baud;
    (st_r == ST_ACK) && forced_r |-> (o_baud_code == BAUD_FORCED);
  endproperty
  a_forced_baud: assert property (p_forced_baud) else $error("acknowledge not at forced rate");
  property p_restore_baud;
    $fell(o_cmd_mode) |-> (o_baud_code == cfg_r.baud);
  endproperty
  a_restore_baud: assert property (p_restore_baud) else $error("rate not restored");
  property p_streak;
    (st_r == ST_DATA) && started_r && (brk_ms_r < BREAK_MS) && uart_byte && !is_esc |=> (esc_cnt_r == 2'h0);
  endproperty
  a_streak: assert property (p_streak) else $error("escape streak survived other byte");
  c_ack_done: cover property ((st_r == ST_ACK) ##1 (st_r == ST_CMD));
  c_break_entry: cover property ((brk_ms_r >= BREAK_MS) ##1 (st_r == ST_ACK));
  c_timeout: cover property ((st_r == ST_CMD) ##1 (st_r == ST_DATA));
  c_cancel: cover property ((st_r == ST_TRAIL) && uart_byte);

endmodule // sme_escape_ctrl

// ---- include/sme_pkg.sv ----
package sme_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int NS_PER_MS = 1000000;
  localparam int MS_PER_S = 1000;
  localparam int TICK_CYCLES_DEF = NS_PER_MS / CLK_PERIOD_NS;
  localparam int MS_W = 16;
  localparam int BREAK_S = 6;
  localparam int ESC_WINDOW_S = 1;
  localparam int GUARD_DEF_S = 1;
  localparam int CMD_TIMEOUT_DEF_S = 10;
  localparam logic [MS_W-1:0] BREAK_MS = MS_W'(BREAK_S * MS_PER_S);
  localparam logic [MS_W-1:0] ESC_WINDOW_MS = MS_W'(ESC_WINDOW_S * MS_PER_S);
  localparam logic [MS_W-1:0] GUARD_DEF_MS = MS_W'(GUARD_DEF_S * MS_PER_S);
  localparam logic [MS_W-1:0] CMD_TIMEOUT_DEF_MS = MS_W'(CMD_TIMEOUT_DEF_S * MS_PER_S);

  ////////////////////////////////////////////////////////////////////////////
  // Codes and characters
  localparam logic [1:0] MODE_TRANSPARENT = 2'h0;
  localparam logic [1:0] MODE_API = 2'h1;
  localparam logic [3:0] BAUD_DEF = 4'h3;
  localparam logic [3:0] BAUD_FORCED = 4'h3;
  localparam logic [1:0] ESC_COUNT = 2'h3;
  localparam logic [1:0] ACK_LAST = 2'h2;
  localparam logic [7:0] ESC_DEF = 8'h2b;
  localparam logic [7:0] CHAR_O = 8'h4f;
  localparam logic [7:0] CHAR_K = 8'h4b;
  localparam logic [7:0] CHAR_CR = 8'h0d;
  localparam logic [7:0] CHAR_A = 8'h41;
  localparam logic [7:0] CHAR_T = 8'h54;
  localparam logic [7:0] CHAR_C = 8'h43;
  localparam logic [7:0] CHAR_N = 8'h4e;
  localparam logic [2:0] EXIT_LAST = 3'h4;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } sme_byte_s;

  typedef struct packed {
    logic [1:0] opmode;
    logic [7:0] esc_char;
    logic [MS_W-1:0] guard_ms;
    logic [MS_W-1:0] timeout_ms;
    logic [3:0] baud;
  } sme_cfg_s;

  localparam sme_cfg_s CFG_RESET = '{
    opmode: MODE_TRANSPARENT,
    esc_char: ESC_DEF,
    guard_ms: GUARD_DEF_MS,
    timeout_ms: CMD_TIMEOUT_DEF_MS,
    baud: BAUD_DEF
  };

  localparam sme_byte_s BYTE_IDLE = '{valid: 1'b0, data: 8'h00};

endpackage

// ---- rtl/sme_exit_scan.sv ----
`timescale 1ns/10ps
module sme_exit_scan (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_clear,
  input sme_pkg::sme_byte_s i_byte,
  output logic o_exit
);
  import sme_pkg::*;

  logic [2:0] idx_r;
  logic [2:0] idx_nxt;
  logic exit_r;
  logic exit_nxt;

  function automatic logic [7:0] exit_char(input logic [2:0] i);
    case (i)
      3'h0: exit_char = CHAR_A;
      3'h1: exit_char = CHAR_T;
      3'h2: exit_char = CHAR_C;
      3'h3: exit_char = CHAR_N;
      default: exit_char = CHAR_CR;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    idx_nxt = idx_r;
    exit_nxt = 1'b0;
    if (i_clear) begin
      idx_nxt = 3'h0;
    end else if (i_byte.valid) begin
      if (i_byte.data == exit_char(idx_r)) begin
        if (idx_r == EXIT_LAST) begin
          idx_nxt = 3'h0;
          exit_nxt = 1'b1;
        end else begin
          idx_nxt = idx_r + 3'h1;
        end
      end else if (i_byte.data == CHAR_A) begin
        // A stray A may start a fresh command
        idx_nxt = 3'h1;
      end else begin
        idx_nxt = 3'h0;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      idx_r <= 3'h0;
      exit_r <= 1'b0;
    end else begin
      idx_r <= idx_nxt;
      exit_r <= exit_nxt;
    end
  end

  assign o_exit = exit_r;

endmodule // sme_exit_scan

// ---- bench/sme_host_model.sv ----
`timescale 1ns/10ps
module sme_host_model (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_slow,
  input sme_pkg::sme_byte_s i_tx,
  output logic o_ready
);
  import sme_pkg::*;
  logic [1:0] cnt_r;
  logic [7:0] got[$];

  ////////////////////////////////////////////////////////////////////////////
  // Slow host takes one byte in three cycles, to stress the held valid
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_r <= 2'h0;
    end else begin
      cnt_r <= (cnt_r == 2'h2) ? 2'h0 : cnt_r + 2'h1;
    end
  end
  assign o_ready = !i_slow || (cnt_r == 2'h0);

  always @(posedge i_clk) begin
    if (i_tx.valid === 1'b1 && o_ready === 1'b1) begin
      got.push_back(i_tx.data);
    end
  end
endmodule // sme_host_model

// ---- bench/tb.sv ----
`timescale 1ns/10ps
module tb;
  import sme_pkg::*;
  logic i_clk, i_rst_n, i_cfg_wr, i_spi_sel, i_rx_break, host_slow, i_uart_tx_ready;
  logic o_net_framed, o_cmd_mode;
  logic [3:0] o_baud_code;
  sme_cfg_s i_cfg, o_cfg, cfg_v;
  sme_byte_s i_uart_rx, i_spi_rx, i_net_rx, o_uart_tx, o_spi_tx, o_net_tx, o_cmd_rx;
  int n_errors = 0;
  int tests_run = 0;
  int n;

  // Ms tick every 4 cycles keeps the six second break within the run
  sme_escape_ctrl #(.TICK_CYCLES(4)) sme_escape_ctrl_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_cfg_wr(i_cfg_wr),
    .i_cfg(i_cfg), .i_spi_sel(i_spi_sel), .i_uart_rx(i_uart_rx), .i_rx_break(i_rx_break), .i_spi_rx(i_spi_rx),
    .i_net_rx(i_net_rx), .i_uart_tx_ready(i_uart_tx_ready), .o_uart_tx(o_uart_tx), .o_spi_tx(o_spi_tx),
    .o_net_tx(o_net_tx), .o_net_framed(o_net_framed), .o_cmd_rx(o_cmd_rx), .o_cmd_mode(o_cmd_mode),
    .o_baud_code(o_baud_code), .o_cfg(o_cfg));
  sme_host_model sme_host_model_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_slow(host_slow), .i_tx(o_uart_tx),
    .o_ready(i_uart_tx_ready));

  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  task automatic tick(input int k = 1);
    repeat (k) @(posedge i_clk);
    #1;
  endtask

  task automatic give_verdict;
    $display("Counts: errors=%0d checks=%0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask

  function automatic sme_byte_s b(input logic [7:0] d);
    return '{valid: 1'b1, data: d};
  endfunction

  // Leading tick keeps valid from being lowered and raised in one step
  task automatic send(input logic spi, input logic [7:0] d);
    tick();
    if (spi) i_spi_rx = b(d);
    else i_uart_rx = b(d);
    tick();
    i_spi_rx = BYTE_IDLE;
    i_uart_rx = BYTE_IDLE;
  endtask

  task automatic net(input logic [7:0] d);
    tick();
    i_net_rx = b(d);
    tick();
    i_net_rx = BYTE_IDLE;
  endtask

  task automatic wcfg(input sme_cfg_s c);
    tick();
    i_cfg = c;
    i_cfg_wr = 1'b1;
    tick();
    i_cfg_wr = 1'b0;
    tick();
  endtask

  task automatic wait_cmd(input logic v, input int maxc);
    n = 0;
    while (o_cmd_mode !== v) begin
      if (n >= maxc) begin
        chk(1'b0, "mode change timed out");
        give_verdict();
      end
      tick();
      n++;
    end
  endtask

  task automatic chk_ack;
    int i;
    i = 0;
    while (sme_host_model_i.got.size() < 3) begin
      if (i >= 400) begin
        chk(1'b0, "acknowledge timed out");
        give_verdict();
      end
      tick();
      i++;
    end
    chk(sme_host_model_i.got[0] === 8'h4f && sme_host_model_i.got[1] === 8'h4b
        && sme_host_model_i.got[2] === 8'h0d, "acknowledge bytes wrong");
  endtask

  // Silence longer than the 5 ms guard (20 cycles), then three escapes
  task automatic escape3(input logic spi);
    tick(30);
    repeat (3) send(spi, 8'h21);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset;
    chk(o_cfg === CFG_RESET, "settings reset value");
    chk(o_cmd_mode === 1'b0 && o_net_framed === 1'b0, "not transparent after reset");
    chk(o_baud_code === 4'h3, "baud reset code");
  endtask

  task automatic t_break_reset;
    logic [7:0] cn[5];
    cn = '{8'h41, 8'h54, 8'h43, 8'h4e, 8'h0d};
    i_rst_n = 1'b0;
    i_rx_break = 1'b1;
    tick(2);
    sme_host_model_i.got.delete();
    i_rst_n = 1'b1;
    wait_cmd(1'b1, 4);
    chk(o_baud_code === 4'h3, "break entry baud");
    i_rx_break = 1'b0;
    chk_ack();
    foreach (cn[k]) send(1'b0, cn[k]);
    wait_cmd(1'b0, 6);
    chk(o_baud_code === 4'h3, "baud after exit");
  endtask

  task automatic t_cfg;
    cfg_v = '{opmode: MODE_TRANSPARENT, esc_char: 8'h21, guard_ms: 16'h0005, timeout_ms: 16'h000a, baud: 4'h5};
    wcfg(cfg_v);
    chk(o_cfg === cfg_v && o_baud_code === 4'h5, "settings write");
  endtask

  task automatic t_pass;
    // Acknowledge bytes of the break test must not count here
    sme_host_model_i.got.delete();
    send(1'b0, 8'h5a);
    chk(o_net_tx === b(8'h5a) && o_net_framed === 1'b0, "serial to network");
    net(8'ha5);
    tick(3);
    chk(sme_host_model_i.got.size() == 1 && sme_host_model_i.got[0] === 8'ha5, "network to serial");
    i_spi_sel = 1'b1;
    send(1'b0, 8'h11);
    chk(o_net_tx.valid === 1'b0, "transparent forward over SPI");
    net(8'h22);
    chk(o_spi_tx.valid === 1'b0, "transparent output on SPI");
    tick(3);
    chk(sme_host_model_i.got.size() == 1, "transparent output with SPI host");
  endtask

  task automatic t_api;
    cfg_v.opmode = MODE_API;
    wcfg(cfg_v);
    send(1'b1, 8'h33);
    chk(o_net_tx === b(8'h33) && o_net_framed === 1'b1, "SPI frame byte to network");
    net(8'h44);
    chk(o_spi_tx === b(8'h44), "network byte to SPI");
    escape3(1'b1);
    tick(60);
    chk(o_cmd_mode === 1'b0, "escape over SPI accepted");
    i_spi_sel = 1'b0;
    send(1'b0, 8'h55);
    chk(o_net_tx === b(8'h55) && o_net_framed === 1'b1, "UART frame byte to network");
    net(8'h66);
    tick(3);
    chk(sme_host_model_i.got.size() == 2 && sme_host_model_i.got[1] === 8'h66, "network frame byte to UART");
    cfg_v.opmode = MODE_TRANSPARENT;
    wcfg(cfg_v);
  endtask

  task automatic t_cancel;
    escape3(1'b0);
    send(1'b0, 8'h0d);
    tick(60);
    chk(o_cmd_mode === 1'b0, "byte in trailing guard ignored");
    tick(30);
    send(1'b0, 8'h21);
    send(1'b0, 8'h41);
    send(1'b0, 8'h21);
    send(1'b0, 8'h21);
    tick(60);
    chk(o_cmd_mode === 1'b0, "broken escape run accepted");
    send(1'b0, 8'h41);
    repeat (3) send(1'b0, 8'h21);
    tick(60);
    chk(o_cmd_mode === 1'b0, "escape without leading guard accepted");
  endtask

  task automatic t_timeout;
    send(1'b0, 8'h33);
    chk(o_cmd_rx === b(8'h33) && o_net_tx.valid === 1'b0, "command byte routing");
    wait_cmd(1'b0, 80);
    chk(n >= 30, "command timeout too early");
    chk(o_baud_code === 4'h5, "baud not restored");
  endtask

  task automatic t_escape;
    host_slow = 1'b1;
    sme_host_model_i.got.delete();
    escape3(1'b0);
    wait_cmd(1'b1, 60);
    chk(n >= 12, "trailing guard too short");
    chk_ack();
    t_timeout();
  endtask

  task automatic t_break;
    host_slow = 1'b0;
    sme_host_model_i.got.delete();
    i_rx_break = 1'b1;
    wait_cmd(1'b1, 25000);
    chk(n >= 23500, "break entry too early");
    chk(o_baud_code === 4'h3, "break entry baud");
    i_rx_break = 1'b0;
    chk_ack();
    t_timeout();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    i_rst_n = 1'b0;
    i_cfg_wr = 1'b0;
    i_cfg = CFG_RESET;
    cfg_v = CFG_RESET;
    i_spi_sel = 1'b0;
    i_rx_break = 1'b0;
    host_slow = 1'b0;
    i_uart_rx = BYTE_IDLE;
    i_spi_rx = BYTE_IDLE;
    i_net_rx = BYTE_IDLE;
    tick(8);
    i_rst_n = 1'b1;
    tick();
    t_reset();
    t_break_reset();
    t_cfg();
    t_pass();
    t_api();
    t_cancel();
    t_escape();
    t_break();
    give_verdict();
  end
endmodule // tb
